/* logic/laser_map.svh */
// Register offsets, field positions, reset values and timing counts of the laser drive link.
// Assumes a 100 MHz system clock on both ends.
`ifndef LASER_MAP_SVH
`define LASER_MAP_SVH
`define OFS_DRIVE_CTRL 7'h1a
`define OFS_CUR_SET 7'h1c
`define OFS_CUR_INV 7'h1d
`define OFS_DRIVE_CTRL_INV 7'h1f
`define BIT_RANGE 7
`define BIT_MATCH 5
`define CAL_MSB 3
`define CAL_LSB 1
`define CAL_ON 3'h7
`define RST_CTRL 8'h00
`define RST_CTRL_INV 8'hff
`define RST_CUR 8'h00
`define RST_CUR_INV 8'hff
`define CLK_PERIOD_NS 10
`define SCLK_HALF_NS 500
`define SCLK_HALF_CYC ((`SCLK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define NCS_SCLK_NS 120
`define NCS_SCLK_CYC ((`NCS_SCLK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_GAP_NS 4000
`define READ_GAP_CYC ((`READ_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_TAIL_NS 20000
`define WRITE_TAIL_CYC ((`WRITE_TAIL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_TAIL_NS 120
`define READ_TAIL_CYC ((`READ_TAIL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SPACE_NS 10000
`define SPACE_CYC ((`SPACE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PULSE_PERIOD_CYC 100
`define PULSE_ON_CYC 20
`define SELFTEST_PERIOD_CYC 4000
`define TEST_SETTLE_CYC 8
`define AV_CTRL 4'h0
`define AV_WDATA 4'h4
`define AV_RDATA 4'h8
`define AV_STATUS 4'hc
`define AV_START_BIT 8
`endif

/* logic/laser_pkg.sv */
// Types shared by the two ends of the laser drive link.
// Assumes nothing of its surroundings.
`default_nettype none
package laser_pkg;
  typedef enum logic [1:0] {ST_RUN, ST_TEST, ST_RECOVER, ST_FAULT} guard_state_t;
  typedef enum logic [2:0] {SP_IDLE, SP_LEAD, SP_SHIFT, SP_GAP, SP_TAIL, SP_SPACE} spi_state_t;
endpackage
`default_nettype wire

/* logic/laser_link_if.sv */
// Four-wire serial port between the sensor and its controller.
// Assumes both ends are clocked by their own clk; the data-out wire idles high.
`default_nettype none
interface laser_link_if;
  logic ncs_n;
  logic sclk;
  logic mosi;
  logic miso_o;
  logic miso_oe_n;
  logic miso;
  assign miso = miso_oe_n ? 1'b1 : miso_o;
  modport sensor (input ncs_n, input sclk, input mosi, output miso_o, output miso_oe_n);
  modport mcu (output ncs_n, output sclk, output mosi, input miso);
endinterface
`default_nettype wire

/* logic/pin_sync.sv */
// Two-flop synchroniser with edge pulses taken behind the second flop.
// Assumes inputs come from outside the clk domain.
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign q = sync_q;
  assign rise = sync_q & ~prev_q;
  assign fall = ~sync_q & prev_q;
endmodule
`default_nettype wire

/* logic/laser_sensor.sv */
// Sensor end: laser drive registers behind the serial port, pulsed or continuous
// drive, and the laser fault guard with its periodic self-test.
// Assumes the pins of the serial port and the pin comparator are asynchronous to clk.
`include "laser_map.svh"
`default_nettype none
module laser_sensor (
  input wire logic clk,
  input wire logic rst,
  laser_link_if.sensor link,
  input wire logic laser_pin_grounded,
  output logic laser_supply_switch_n,
  output logic laser_current_en,
  output logic [7:0] laser_current_code,
  output logic laser_range_high,
  output logic laser_bin_match,
  output logic laser_pin_pulldown,
  output logic laser_fault
);
  // ****************************************
  // Pin synchronisation
  // ****************************************
  logic [3:0] pins_s;
  logic [3:0] pins_rise;
  logic [3:0] pins_fall;

  // Select and serial clock enter inverted, so the synchroniser's reset level is their idle level.
  pin_sync #(.W(4)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({laser_pin_grounded, link.mosi, ~link.sclk, ~link.ncs_n}),
    .q(pins_s),
    .rise(pins_rise),
    .fall(pins_fall)
  );

  wire ncs_n_s = ~pins_s[0];
  wire sclk_rise = pins_fall[1];
  wire sclk_fall = pins_rise[1];
  wire mosi_s = pins_s[2];
  wire grounded_s = pins_s[3];

  // ****************************************
  // Register file
  // ****************************************
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_inv_q;
  logic [7:0] cur_q;
  logic [7:0] cur_inv_q;

  function automatic logic [7:0] reg_read(input logic [6:0] a, input logic [7:0] c,
                                          input logic [7:0] ci, input logic [7:0] s,
                                          input logic [7:0] si);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `OFS_DRIVE_CTRL: v = c;
      `OFS_DRIVE_CTRL_INV: v = ci;
      `OFS_CUR_SET: v = s;
      `OFS_CUR_INV: v = si;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // ****************************************
  // Serial port slave
  // ****************************************
  logic [3:0] bit_cnt_q;
  logic [7:0] addr_q;
  logic [7:0] shift_q;
  logic miso_q;
  logic miso_oe_n_q;

  wire active = ~ncs_n_s;
  wire [7:0] shift_d = {shift_q[6:0], mosi_s};
  wire byte_write = active & sclk_rise & (bit_cnt_q == 4'hf) & addr_q[7];
  wire [6:0] waddr = addr_q[6:0];
  wire wr_ctrl = byte_write & (waddr == `OFS_DRIVE_CTRL);
  wire wr_ctrl_inv = byte_write & (waddr == `OFS_DRIVE_CTRL_INV);
  wire wr_cur = byte_write & (waddr == `OFS_CUR_SET);
  wire wr_cur_inv = byte_write & (waddr == `OFS_CUR_INV);
  wire [7:0] rd_val = reg_read(addr_q[6:0], ctrl_q, ctrl_inv_q, cur_q, cur_inv_q);
  wire drive_out = active & sclk_fall & bit_cnt_q[3] & ~addr_q[7];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_cnt_q <= 4'h0;
      addr_q <= 8'h00;
      shift_q <= 8'h00;
    end else if (!active) begin
      bit_cnt_q <= 4'h0;
    end else if (sclk_rise) begin
      shift_q <= shift_d;
      bit_cnt_q <= bit_cnt_q + 4'h1;
      if (bit_cnt_q == 4'h7) begin
        addr_q <= shift_d;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      miso_q <= 1'b1;
      miso_oe_n_q <= 1'b1;
    end else if (!active) begin
      miso_oe_n_q <= 1'b1;
    end else if (drive_out) begin
      miso_q <= rd_val[~bit_cnt_q[2:0]];
      miso_oe_n_q <= 1'b0;
    end
  end

  assign link.miso_o = miso_q;
  assign link.miso_oe_n = miso_oe_n_q;

  // Every reset returns the registers to a safe minimum; the controller reloads them.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `RST_CTRL;
      ctrl_inv_q <= `RST_CTRL_INV;
      cur_q <= `RST_CUR;
      cur_inv_q <= `RST_CUR_INV;
    end else begin
      if (wr_ctrl) ctrl_q <= shift_d;
      if (wr_ctrl_inv) ctrl_inv_q <= shift_d;
      if (wr_cur) cur_q <= shift_d;
      if (wr_cur_inv) cur_inv_q <= shift_d;
    end
  end

  // ****************************************
  // Drive settings
  // ****************************************
  // A setting other than bin match only takes effect while both inverse copies agree; otherwise drive stays off.
  wire ctrl_ok = (ctrl_q == ~ctrl_inv_q);
  wire cur_ok = (cur_q == ~cur_inv_q);
  wire settings_ok = ctrl_ok & cur_ok;
  wire range_d = settings_ok & ctrl_q[`BIT_RANGE];
  wire match_d = ctrl_q[`BIT_MATCH];
  wire cal_on = settings_ok & (ctrl_q[`CAL_MSB:`CAL_LSB] == `CAL_ON);

  logic [7:0] pulse_cnt_q;
  wire pulse_wrap = (pulse_cnt_q == 8'(`PULSE_PERIOD_CYC - 1));
  wire pulse_on = (pulse_cnt_q < 8'(`PULSE_ON_CYC));
  wire drive_want = settings_ok & (cal_on | pulse_on);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pulse_cnt_q <= 8'h00;
    end else begin
      pulse_cnt_q <= pulse_wrap ? 8'h00 : pulse_cnt_q + 8'h01;
    end
  end

  // ****************************************
  // Fault guard and self-test
  // ****************************************
  laser_pkg::guard_state_t state_q;
  laser_pkg::guard_state_t state_d;
  logic [11:0] test_cnt_q;
  logic [3:0] settle_cnt_q;

  wire test_due = (test_cnt_q == 12'(`SELFTEST_PERIOD_CYC - 1));
  wire settled = (settle_cnt_q == 4'(`TEST_SETTLE_CYC - 1));

  always_comb begin
    state_d = state_q;
    case (state_q)
      laser_pkg::ST_RUN: begin
        if (grounded_s) begin
          state_d = laser_pkg::ST_FAULT;
        end else if (test_due) begin
          state_d = laser_pkg::ST_TEST;
        end
      end
      laser_pkg::ST_TEST: begin
        if (settled) begin
          state_d = grounded_s ? laser_pkg::ST_RECOVER : laser_pkg::ST_FAULT;
        end
      end
      laser_pkg::ST_RECOVER: begin
        if (settled) begin
          state_d = laser_pkg::ST_RUN;
        end
      end
      laser_pkg::ST_FAULT: state_d = laser_pkg::ST_FAULT;
      default: state_d = laser_pkg::ST_FAULT;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= laser_pkg::ST_RUN;
      test_cnt_q <= 12'h000;
      settle_cnt_q <= 4'h0;
    end else begin
      state_q <= state_d;
      test_cnt_q <= (state_q == laser_pkg::ST_RUN) ? test_cnt_q + 12'h001 : 12'h000;
      settle_cnt_q <= (state_d == state_q) ? settle_cnt_q + 4'h1 : 4'h0;
    end
  end

  // ****************************************
  // Laser outputs
  // ****************************************
  wire running = (state_d == laser_pkg::ST_RUN) | (state_d == laser_pkg::ST_RECOVER);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      laser_supply_switch_n <= 1'b1;
      laser_current_en <= 1'b0;
      laser_current_code <= 8'h00;
      laser_range_high <= 1'b0;
      laser_bin_match <= 1'b0;
      laser_pin_pulldown <= 1'b0;
      laser_fault <= 1'b0;
    end else begin
      laser_supply_switch_n <= ~running;
      laser_current_en <= (state_d == laser_pkg::ST_RUN) & drive_want;
      laser_current_code <= settings_ok ? cur_q : 8'h00;
      laser_range_high <= range_d;
      laser_bin_match <= match_d;
      laser_pin_pulldown <= (state_d == laser_pkg::ST_TEST);
      laser_fault <= (state_d == laser_pkg::ST_FAULT);
    end
  end
endmodule
`default_nettype wire

/* logic/laser_mcu.sv */
// Controller end: runs one serial register access per software command.
// Assumes an Avalon-MM master on clk; the miso pin is asynchronous to clk.
`include "laser_map.svh"
`default_nettype none
module laser_mcu (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  laser_link_if.mcu link
);
  // ****************************************
  // Avalon slave
  // ****************************************
  logic [6:0] cmd_addr_q;
  logic cmd_wr_q;
  logic [7:0] wdata_q;
  logic [7:0] rdata_q;
  logic busy_q;
  logic done_q;

  wire acc = (avs_read | avs_write) & ~avs_waitrequest;
  wire wr_ctrl = acc & avs_write & (avs_address == `AV_CTRL) & ~busy_q;
  wire start = wr_ctrl & avs_writedata[`AV_START_BIT];
  wire wr_wdata = acc & avs_write & (avs_address == `AV_WDATA);
  wire [31:0] rd_mux = (avs_address == `AV_CTRL) ? {23'h0, busy_q, cmd_wr_q, cmd_addr_q} :
                       (avs_address == `AV_WDATA) ? {24'h0, wdata_q} :
                       (avs_address == `AV_RDATA) ? {24'h0, rdata_q} :
                       (avs_address == `AV_STATUS) ? {30'h0, done_q, busy_q} : 32'h0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
      cmd_addr_q <= 7'h00;
      cmd_wr_q <= 1'b0;
      wdata_q <= 8'h00;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      avs_readdata <= rd_mux;
      if (wr_ctrl) begin
        cmd_addr_q <= avs_writedata[6:0];
        cmd_wr_q <= avs_writedata[7];
      end
      if (wr_wdata) wdata_q <= avs_writedata[7:0];
    end
  end

  // ****************************************
  // Serial engine
  // ****************************************
  logic [0:0] miso_s;
  laser_pkg::spi_state_t st_q;
  logic [15:0] cnt_q;
  logic [7:0] shift_q;
  logic [2:0] bit_q;
  logic second_q;
  logic ncs_n_q;
  logic sclk_q;
  logic mosi_q;

  pin_sync #(.W(1)) u_sync (
    .clk(clk),
    .rst(rst),
    .d(link.miso),
    .q(miso_s),
    .rise(),
    .fall()
  );

  wire tick = (cnt_q == 16'h0000);
  wire [7:0] shift_in = {shift_q[6:0], miso_s[0]};
  wire [15:0] half = 16'(`SCLK_HALF_CYC - 1);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= laser_pkg::SP_IDLE;
      cnt_q <= 16'h0000;
      shift_q <= 8'h00;
      bit_q <= 3'h0;
      second_q <= 1'b0;
      ncs_n_q <= 1'b1;
      sclk_q <= 1'b1;
      mosi_q <= 1'b1;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      if (!tick) cnt_q <= cnt_q - 16'h0001;
      case (st_q)
        laser_pkg::SP_IDLE: begin
          if (start) begin
            busy_q <= 1'b1;
            done_q <= 1'b0;
            shift_q <= {avs_writedata[7], avs_writedata[6:0]};
            bit_q <= 3'h0;
            second_q <= 1'b0;
            ncs_n_q <= 1'b0;
            cnt_q <= 16'(`NCS_SCLK_CYC);
            st_q <= laser_pkg::SP_LEAD;
          end
        end
        laser_pkg::SP_LEAD: if (tick) st_q <= laser_pkg::SP_SHIFT;
        laser_pkg::SP_GAP: if (tick) st_q <= laser_pkg::SP_SHIFT;
        laser_pkg::SP_SHIFT: begin
          if (tick && sclk_q) begin
            sclk_q <= 1'b0;
            mosi_q <= shift_q[7];
            cnt_q <= half;
          end else if (tick) begin
            sclk_q <= 1'b1;
            shift_q <= shift_in;
            bit_q <= bit_q + 3'h1;
            cnt_q <= half;
            if (bit_q == 3'h7 && !second_q) begin
              second_q <= 1'b1;
              shift_q <= wdata_q;
              if (!cmd_wr_q) begin
                cnt_q <= 16'(`READ_GAP_CYC);
                st_q <= laser_pkg::SP_GAP;
              end
            end else if (bit_q == 3'h7) begin
              if (!cmd_wr_q) rdata_q <= shift_in;
              cnt_q <= cmd_wr_q ? 16'(`WRITE_TAIL_CYC) : 16'(`READ_TAIL_CYC);
              st_q <= laser_pkg::SP_TAIL;
            end
          end
        end
        laser_pkg::SP_TAIL: begin
          if (tick) begin
            ncs_n_q <= 1'b1;
            cnt_q <= 16'(`SPACE_CYC);
            st_q <= laser_pkg::SP_SPACE;
          end
        end
        laser_pkg::SP_SPACE: begin
          if (tick) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
            st_q <= laser_pkg::SP_IDLE;
          end
        end
        default: st_q <= laser_pkg::SP_IDLE;
      endcase
    end
  end

  assign link.ncs_n = ncs_n_q;
  assign link.sclk = sclk_q;
  assign link.mosi = mosi_q;
endmodule
`default_nettype wire

/* tb/laser_link_sva.sv */
// Concurrent checks on the serial link and on the laser guard outputs.
// Assumes one clk domain and an asynchronous active-high rst.
`include "laser_map.svh"
`default_nettype none
module laser_link_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic ncs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso_oe_n,
  input wire logic laser_pin_grounded,
  input wire logic laser_supply_switch_n,
  input wire logic laser_current_en,
  input wire logic laser_pin_pulldown,
  input wire logic laser_fault
);
  logic sclk_prev_q;
  logic [15:0] run_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ****
  // Length of the present serial clock level, in clk cycles.
  // ****
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_prev_q <= 1'h1;
      run_q <= 16'h0;
    end else begin
      sclk_prev_q <= sclk;
      if (sclk != sclk_prev_q) begin
        run_q <= 16'h1;
      end else if (run_q != 16'hffff) begin
        run_q <= run_q + 16'h1;
      end
    end
  end
  a_fault_kills_laser: assert property (
    laser_fault |-> laser_supply_switch_n && !laser_current_en)
    else $error("laser left on during fault");
  a_ground_trips_fault: assert property (
    (laser_pin_grounded && !laser_pin_pulldown) [*8] |-> ##[0:8] laser_fault)
    else $error("grounded drive pin not reported");
  a_supply_when_healthy: assert property (
    (!laser_fault && !laser_pin_pulldown) [*8] ##1 (!laser_fault && !laser_pin_pulldown) [*8]
    |-> !laser_supply_switch_n)
    else $error("supply switch off while healthy");
  a_test_turns_off: assert property (
    laser_pin_pulldown |-> laser_supply_switch_n && !laser_current_en)
    else $error("laser on during self-test");
  a_test_length: assert property (
    $rose(laser_pin_pulldown) |-> laser_pin_pulldown [*8] ##1 (!laser_pin_pulldown || laser_fault))
    else $error("self-test length wrong");
  a_supply_short_fault: assert property (
    (laser_pin_pulldown && !laser_pin_grounded) [*8] |-> ##[0:4] laser_fault)
    else $error("failed self-test not reported");
  a_select_lead: assert property (
    $fell(ncs_n) |-> sclk [*6] ##1 sclk [*6])
    else $error("serial clock too soon after select");
  a_sclk_low_half: assert property (
    sclk && !sclk_prev_q |-> run_q == `SCLK_HALF_CYC)
    else $error("serial clock low half wrong");
  a_sclk_idle_high: assert property (
    ncs_n |-> sclk)
    else $error("serial clock not idle high");
  a_mosi_stable: assert property (
    !ncs_n && $past(!ncs_n) && sclk && $past(sclk) |-> $stable(mosi))
    else $error("data changed while serial clock high");
  a_miso_release: assert property (
    $rose(ncs_n) |-> ##[0:50] miso_oe_n)
    else $error("data out not released");
endmodule
`default_nettype wire

/* tb/laser_drive_safety_control_tb_top.sv */
// Bench joining the controller and sensor ends over the serial link.
// Assumes a 100 MHz clk and the map in laser_map.svh.
`include "laser_map.svh"
`default_nettype none
module laser_drive_safety_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic pin_gnd = 1'h0;
  logic short_gnd = 1'h0;
  logic short_vdd = 1'h0;
  logic sw_n, cur_en, rng, match, pull, fault;
  logic [7:0] code;
  logic [7:0] sh [4];
  logic [6:0] ofs [4];
  int n_fail = 0;
  int n_compared = 0;
  int seed = 82;
  laser_link_if link ();
  laser_mcu laser_mcu_inst (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(link));
  laser_sensor laser_sensor_inst (.clk(clk), .rst(rst), .link(link),
    .laser_pin_grounded(pin_gnd), .laser_supply_switch_n(sw_n), .laser_current_en(cur_en),
    .laser_current_code(code), .laser_range_high(rng), .laser_bin_match(match),
    .laser_pin_pulldown(pull), .laser_fault(fault));
  laser_link_sva laser_link_sva_inst (.clk(clk), .rst(rst), .ncs_n(link.ncs_n),
    .sclk(link.sclk), .mosi(link.mosi), .miso_oe_n(link.miso_oe_n),
    .laser_pin_grounded(pin_gnd), .laser_supply_switch_n(sw_n), .laser_current_en(cur_en),
    .laser_pin_pulldown(pull), .laser_fault(fault));
  always #5 clk = !clk;
  // ****
  // Drive pin comparator: follows the internal ground unless a short is set.
  // ****
  always @(posedge clk) pin_gnd <= (pull & !short_vdd) | short_gnd;
  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic timeout(input string m);
    n_fail++;
    $display("[FAIL] %0t no answer on %s", $time, m);
    print_verdict();
  endtask
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int i;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (avs_waitrequest !== 1'h0 && i < 50);
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    if (i >= 50) timeout("bus");
  endtask
  task automatic reg_op(input logic wr, input logic [6:0] a, input logic [7:0] d,
                        output logic [7:0] q);
    logic [31:0] r;
    int i;
    av(1'h1, `AV_WDATA, {24'h0, d}, r);
    av(1'h1, `AV_CTRL, {23'h0, 1'h1, wr, a}, r);
    i = 0;
    r = 32'h0;
    while (r[1] !== 1'h1 && i < 4000) begin
      av(1'h0, `AV_STATUS, 32'h0, r);
      i++;
    end
    if (i >= 4000) timeout("link");
    av(1'h0, `AV_RDATA, 32'h0, r);
    q = r[7:0];
  endtask
  task automatic wr_reg(input int k, input logic [7:0] v);
    logic [7:0] b;
    sh[k] = v;
    reg_op(1'h1, ofs[k], v, b);
  endtask
  function automatic logic pairs_ok();
    return sh[0] === ~sh[1] && sh[2] === ~sh[3];
  endfunction
  task automatic check_out;
    chk(code, pairs_ok() ? sh[2] : 8'h00, "current code");
    chk(rng, pairs_ok() & sh[0][`BIT_RANGE], "range");
    chk(match, sh[0][`BIT_MATCH], "bin match");
  endtask
  // A window that saw a self-test, or its recovery tail, is measured again.
  task automatic duty(output int n);
    logic t;
    int q;
    t = 1'h1;
    q = 0;
    for (int k = 0; k < 4 && t; k++) begin
      n = 0;
      t = 1'h0;
      repeat (100) begin
        @(posedge clk);
        n += int'(cur_en);
        q = pull ? 0 : q + 1;
        t |= (q < 16);
      end
    end
  endtask
  task automatic wait_fault(input int lim);
    int i;
    i = 0;
    while (fault !== 1'h1 && i < lim) begin
      @(posedge clk);
      i++;
    end
    if (i >= lim) timeout("fault");
  endtask
  initial begin
    logic [31:0] r;
    logic [7:0] b, v;
    int n;
    ofs = '{`OFS_DRIVE_CTRL, `OFS_DRIVE_CTRL_INV, `OFS_CUR_SET, `OFS_CUR_INV};
    sh = '{`RST_CTRL, `RST_CTRL_INV, `RST_CUR, `RST_CUR_INV};
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    repeat (2) @(posedge clk);
    chk(sw_n, 1'h0, "supply switch");
    av(1'h0, 4'h2, 32'h0, r);
    chk(r, 32'h0, "unmapped bus read");
    for (int k = 0; k < 4; k++) begin
      reg_op(1'h0, ofs[k], 8'h00, b);
      chk(b, sh[k], "reset value");
    end
    reg_op(1'h0, 7'h1b, 8'h00, b);
    chk(b, 8'h00, "unmapped register");
    wr_reg(0, 8'h2e);
    wr_reg(1, 8'hd1);
    wr_reg(2, 8'h00);
    wr_reg(3, 8'hff);
    check_out();
    duty(n);
    chk(n, 100, "calibration duty");
    repeat (2) begin
      v = 8'($random(seed));
      wr_reg(2, v);
      wr_reg(3, ~v);
      check_out();
      reg_op(1'h0, ofs[2], 8'h00, b);
      chk(b, v, "current readback");
    end
    wr_reg(0, 8'ha0);
    wr_reg(1, 8'h5f);
    check_out();
    duty(n);
    chk(n, 20, "pulsed duty");
    wr_reg(0, 8'h80);
    check_out();
    short_vdd <= 1'h1;
    wait_fault(4200);
    chk(sw_n, 1'h1, "switch after failed test");
    chk(cur_en, 1'h0, "current after failed test");
    rst <= 1'h1;
    short_vdd <= 1'h0;
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    sh = '{`RST_CTRL, `RST_CTRL_INV, `RST_CUR, `RST_CUR_INV};
    reg_op(1'h0, ofs[0], 8'h00, b);
    chk(b, sh[0], "control after reset");
    chk(fault, 1'h0, "fault cleared");
    short_gnd <= 1'h1;
    wait_fault(40);
    chk(sw_n, 1'h1, "switch after ground");
    chk(cur_en, 1'h0, "current after ground");
    print_verdict();
  end
endmodule
`default_nettype wire
